/* File: verilog/dtc_pkg.sv */
// Shared constants and types for the delay tap calibrator controller
package dtc_pkg;
  localparam int TAP_W = 9;
  localparam logic [8:0] TAP_MAX = 9'h1FF;
  localparam int TAPS_PER_LINE = 512;
  localparam int LINE_MIN_PS = 1250;
  localparam int ALIGN_MIN_TAPS = 45;
  localparam int ALIGN_MAX_TAPS = 65;
  // Fraction bits of the single-tap delay (ps scaled by 256)
  localparam int TAP_FRAC = 8;
  localparam int CLK_PERIOD_NS = 10;
  // Gap after each load strobe, clock cycles
  localparam logic [3:0] LOAD_GAP_CYC = 4'h5;
  // Settle time around drift-compensation changes, in ns and cycles
  localparam int SETTLE_NS = 100;
  localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_SET_PS = 8'h08;
  localparam logic [7:0] REG_WANT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_ALIGN = 8'h14;
  localparam logic [7:0] REG_TAP_PS = 8'h18;
  localparam logic [7:0] REG_RDBK = 8'h1C;
  localparam logic [7:0] REG_RESULT = 8'h20;

  // Field positions
  localparam int CMD_LOAD = 0;
  localparam int CMD_CAL = 1;
  localparam int CFG_COUNT = 0;
  localparam int CFG_ALT = 1;
  localparam int CFG_DIFF = 2;
  localparam int CFG_SLICE = 3;
  localparam int CFG_TX = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_CALOK = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_CLAMPED = 3;
  localparam int ST_CALERR = 4;
  localparam int RDBK_HI = 16;

  localparam logic [15:0] SET_PS_RESET = 16'h02BC;

  typedef enum logic [8:0] {
    DTC_IDLE = 9'h001,
    DTC_PRE = 9'h002,
    DTC_READ = 9'h004,
    DTC_CALC = 9'h008,
    DTC_PRESENT = 9'h010,
    DTC_STROBE = 9'h020,
    DTC_GAP = 9'h040,
    DTC_POST = 9'h080,
    DTC_CAL = 9'h100
  } dtc_state_t;
endpackage

/* File: verilog/dtc_delay_tap_calibrator.sv */
// Host controller that calibrates and parallel-loads two delay lines
module dtc_delay_tap_calibrator (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic [8:0] tapReadback0,
  input wire logic [8:0] tapReadback1,
  output logic [8:0] tapLoadValue0,
  output logic [8:0] tapLoadValue1,
  output logic tapLoad0,
  output logic tapLoad1,
  output logic driftCompensationEnable0,
  output logic driftCompensationEnable1,
  input wire logic [7:0] slice1Data,
  output logic [7:0] slice1DataUser
);

  typedef struct packed {
    dtc_pkg::dtc_state_t state;
    logic [3:0] cnt;
    logic drift;
    logic load0;
    logic load1;
    logic [8:0] tap0;
    logic [8:0] tap1;
    logic countFmt;
    logic calAlt;
    logic diffPair;
    logic tgtSlice;
    logic tgtTx;
    logic [15:0] setPs;
    logic [15:0] want;
    logic [8:0] align;
    logic [23:0] tapPs;
    logic calOk;
    logic [8:0] held0;
    logic [8:0] held1;
    logic [8:0] result;
    logic stRefused;
    logic stClamped;
    logic stCalErr;
    logic [31:0] rdData;
    logic [7:0] s1Data;
  } dtc_regs_t;

  dtc_regs_t cur_ff;
  dtc_regs_t nxt_cur;

  // Division guarded against zero divisor: saturates instead
  function automatic logic [31:0] divSat(input logic [31:0] num, input logic [31:0] den);
    logic [31:0] q;
    q = 32'hFFFFFFFF;
    if (den != 32'h0) begin
      q = num / den;
    end
    return q;
  endfunction

  // Saturate a wide count to the line depth
  function automatic logic [8:0] clampTap(input logic [31:0] v);
    logic [8:0] t;
    t = v[8:0];
    if (v > 32'(dtc_pkg::TAP_MAX)) begin
      t = dtc_pkg::TAP_MAX;
    end
    return t;
  endfunction

  logic [31:0] quot;
  logic [31:0] rawTaps;
  logic [31:0] calSpan;
  logic [8:0] calOffset;
  logic calNeg;
  logic [31:0] calQuot;

  always_comb begin
    quot = divSat({8'h00, cur_ff.want, 8'h00}, {8'h00, cur_ff.tapPs});
    // count format takes the word as taps
    if (cur_ff.countFmt) begin
      rawTaps = {16'h0000, cur_ff.want};
    end else if (cur_ff.tgtTx) begin
      rawTaps = quot;
    end else begin
      rawTaps = quot + {23'h0, cur_ff.align};
    end
    if (cur_ff.calAlt) begin
      // output count alone is the set delay
      calSpan = {23'h0, tapReadback1};
      calOffset = 9'(tapReadback0 - tapReadback1);
      calNeg = tapReadback0 < tapReadback1;
    end else begin
      // even is offset, odd minus even is span
      calSpan = {23'h0, 9'(tapReadback1 - tapReadback0)};
      calOffset = tapReadback0;
      calNeg = tapReadback1 < tapReadback0;
    end
    // set delay over span, ps scaled by 256
    calQuot = divSat({8'h00, cur_ff.setPs, 8'h00}, calSpan);
  end

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.load0 = 1'b0;
    nxt_cur.load1 = 1'b0;
    // negative side of a dual-output pair
    nxt_cur.s1Data = cur_ff.diffPair ? ~slice1Data : slice1Data;

    if (regWr) begin
      case (regAddr)
        dtc_pkg::REG_CFG: begin
          if (cur_ff.state == dtc_pkg::DTC_IDLE) begin
            nxt_cur.countFmt = regWrData[dtc_pkg::CFG_COUNT];
            nxt_cur.calAlt = regWrData[dtc_pkg::CFG_ALT];
            // dual-output pair inverts the odd slice data
            nxt_cur.diffPair = regWrData[dtc_pkg::CFG_DIFF];
            nxt_cur.tgtSlice = regWrData[dtc_pkg::CFG_SLICE];
            nxt_cur.tgtTx = regWrData[dtc_pkg::CFG_TX];
          end
        end
        dtc_pkg::REG_SET_PS: nxt_cur.setPs = regWrData[15:0];
        dtc_pkg::REG_WANT: nxt_cur.want = regWrData[15:0];
        dtc_pkg::REG_STATUS: begin
          if (regWrData[dtc_pkg::ST_REFUSED]) begin
            nxt_cur.stRefused = 1'b0;
          end
          if (regWrData[dtc_pkg::ST_CLAMPED]) begin
            nxt_cur.stClamped = 1'b0;
          end
          if (regWrData[dtc_pkg::ST_CALERR]) begin
            nxt_cur.stCalErr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // compensation on while idle in time format
    case (cur_ff.state)
      dtc_pkg::DTC_IDLE: begin
        nxt_cur.drift = ~cur_ff.countFmt;
        nxt_cur.cnt = 4'h0;
        if (regWr && regAddr == dtc_pkg::REG_CMD) begin
          if (regWrData[dtc_pkg::CMD_CAL]) begin
            nxt_cur.state = dtc_pkg::DTC_CAL;
          end else if (regWrData[dtc_pkg::CMD_LOAD]) begin
            nxt_cur.drift = 1'b0;
            nxt_cur.state = cur_ff.countFmt ? dtc_pkg::DTC_READ : dtc_pkg::DTC_PRE;
          end
        end
      end
      dtc_pkg::DTC_PRE: begin
        // Line must be quiet before its count is trusted
        nxt_cur.cnt = 4'(cur_ff.cnt + 4'h1);
        if (cur_ff.cnt == 4'(dtc_pkg::SETTLE_CYC - 4'h1)) begin
          nxt_cur.state = dtc_pkg::DTC_READ;
        end
      end
      dtc_pkg::DTC_READ: begin
        nxt_cur.held0 = tapReadback0;
        nxt_cur.held1 = tapReadback1;
        nxt_cur.state = dtc_pkg::DTC_CALC;
      end
      dtc_pkg::DTC_CALC: begin
        nxt_cur.result = clampTap(rawTaps);
        if (rawTaps > 32'(dtc_pkg::TAP_MAX)) begin
          nxt_cur.stClamped = 1'b1;
        end
        // refuse zero, below offset or uncalibrated on time-format input lines
        if (!cur_ff.countFmt && !cur_ff.tgtTx &&
            (rawTaps == 32'h0 || rawTaps < {23'h0, cur_ff.align} || !cur_ff.calOk)) begin
          nxt_cur.stRefused = 1'b1;
          nxt_cur.cnt = 4'h0;
          nxt_cur.state = dtc_pkg::DTC_POST;
        end else begin
          nxt_cur.state = dtc_pkg::DTC_PRESENT;
        end
      end
      dtc_pkg::DTC_PRESENT: begin
        // value on the bus ahead of the strobe
        if (cur_ff.tgtSlice) begin
          nxt_cur.tap1 = cur_ff.result;
        end else begin
          nxt_cur.tap0 = cur_ff.result;
        end
        nxt_cur.state = dtc_pkg::DTC_STROBE;
      end
      dtc_pkg::DTC_STROBE: begin
        nxt_cur.load0 = ~cur_ff.tgtSlice;
        nxt_cur.load1 = cur_ff.tgtSlice;
        nxt_cur.cnt = 4'h0;
        nxt_cur.state = dtc_pkg::DTC_GAP;
      end
      dtc_pkg::DTC_GAP: begin
        // five idle cycles before any next value
        nxt_cur.cnt = 4'(cur_ff.cnt + 4'h1);
        if (cur_ff.cnt == 4'(dtc_pkg::LOAD_GAP_CYC - 4'h1)) begin
          nxt_cur.cnt = 4'h0;
          nxt_cur.state = cur_ff.countFmt ? dtc_pkg::DTC_IDLE : dtc_pkg::DTC_POST;
        end
      end
      dtc_pkg::DTC_POST: begin
        nxt_cur.cnt = 4'(cur_ff.cnt + 4'h1);
        if (cur_ff.cnt == 4'(dtc_pkg::SETTLE_CYC - 4'h1)) begin
          nxt_cur.state = dtc_pkg::DTC_IDLE;
        end
      end
      dtc_pkg::DTC_CAL: begin
        // even slice at zero (at setPs with calAlt), odd at setPs
        // single tap is set delay over span
        nxt_cur.tapPs = calQuot[23:0];
        nxt_cur.align = calOffset;
        nxt_cur.held0 = tapReadback0;
        nxt_cur.held1 = tapReadback1;
        // offset must sit in the reserved window
        if (calSpan == 32'h0 || calNeg ||
            calOffset < 9'(dtc_pkg::ALIGN_MIN_TAPS) || calOffset > 9'(dtc_pkg::ALIGN_MAX_TAPS)) begin
          nxt_cur.calOk = 1'b0;
          nxt_cur.stCalErr = 1'b1;
        end else begin
          nxt_cur.calOk = 1'b1;
        end
        nxt_cur.state = dtc_pkg::DTC_IDLE;
      end
      default: nxt_cur.state = dtc_pkg::DTC_IDLE;
    endcase

    nxt_cur.rdData = 32'h0;
    if (regRd) begin
      case (regAddr)
        dtc_pkg::REG_CFG: begin
          nxt_cur.rdData[dtc_pkg::CFG_COUNT] = cur_ff.countFmt;
          nxt_cur.rdData[dtc_pkg::CFG_ALT] = cur_ff.calAlt;
          nxt_cur.rdData[dtc_pkg::CFG_DIFF] = cur_ff.diffPair;
          nxt_cur.rdData[dtc_pkg::CFG_SLICE] = cur_ff.tgtSlice;
          nxt_cur.rdData[dtc_pkg::CFG_TX] = cur_ff.tgtTx;
        end
        dtc_pkg::REG_SET_PS: nxt_cur.rdData[15:0] = cur_ff.setPs;
        dtc_pkg::REG_WANT: nxt_cur.rdData[15:0] = cur_ff.want;
        dtc_pkg::REG_STATUS: begin
          nxt_cur.rdData[dtc_pkg::ST_BUSY] = cur_ff.state != dtc_pkg::DTC_IDLE;
          nxt_cur.rdData[dtc_pkg::ST_CALOK] = cur_ff.calOk;
          nxt_cur.rdData[dtc_pkg::ST_REFUSED] = cur_ff.stRefused;
          nxt_cur.rdData[dtc_pkg::ST_CLAMPED] = cur_ff.stClamped;
          nxt_cur.rdData[dtc_pkg::ST_CALERR] = cur_ff.stCalErr;
        end
        dtc_pkg::REG_ALIGN: nxt_cur.rdData[8:0] = cur_ff.align;
        dtc_pkg::REG_TAP_PS: nxt_cur.rdData[23:0] = cur_ff.tapPs;
        dtc_pkg::REG_RDBK: begin
          nxt_cur.rdData[8:0] = cur_ff.held0;
          nxt_cur.rdData[dtc_pkg::RDBK_HI +: 9] = cur_ff.held1;
        end
        dtc_pkg::REG_RESULT: nxt_cur.rdData[8:0] = cur_ff.result;
        default: nxt_cur.rdData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
      cur_ff.state <= dtc_pkg::DTC_IDLE;
      cur_ff.setPs <= dtc_pkg::SET_PS_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign regRdData = cur_ff.rdData;
  assign tapLoadValue0 = cur_ff.tap0;
  assign tapLoadValue1 = cur_ff.tap1;
  assign tapLoad0 = cur_ff.load0;
  assign tapLoad1 = cur_ff.load1;
  assign driftCompensationEnable0 = cur_ff.drift;
  assign driftCompensationEnable1 = cur_ff.drift;
  assign slice1DataUser = cur_ff.s1Data;

endmodule

/* File: tb/dtc_checker.sv */
// Port-level assertions for the delay tap calibrator
module dtc_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic [8:0] tapLoadValue0,
  input wire logic [8:0] tapLoadValue1,
  input wire logic tapLoad0,
  input wire logic tapLoad1,
  input wire logic driftCompensationEnable0,
  input wire logic driftCompensationEnable1,
  input wire logic [7:0] slice1Data,
  input wire logic [7:0] slice1DataUser
);
  logic [3:0] sinceLoad_ff;
  logic [3:0] nxt_sinceLoad;
  // Saturates so reset looks like a long-ago load
  always_comb begin
    nxt_sinceLoad = sinceLoad_ff;
    if (tapLoad0 || tapLoad1) begin
      nxt_sinceLoad = 4'h0;
    end else if (sinceLoad_ff != 4'hF) begin
      nxt_sinceLoad = sinceLoad_ff + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sinceLoad_ff <= 4'hF;
    end else begin
      sinceLoad_ff <= nxt_sinceLoad;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_quiet;
    !tapLoad0 && !tapLoad1 && $stable(tapLoadValue0) && $stable(tapLoadValue1);
  endsequence
  property p_pulse;
    (tapLoad0 || tapLoad1) |=> !tapLoad0 && !tapLoad1;
  endproperty
  a_pulse: assert property (p_pulse) else $error("load strobe too long");
  property p_present;
    (tapLoad0 || tapLoad1) |-> $stable(tapLoadValue0) && $stable(tapLoadValue1);
  endproperty
  a_present: assert property (p_present) else $error("value not ahead of strobe");
  property p_gap;
    (tapLoad0 || tapLoad1) |=> s_quiet [*5];
  endproperty
  a_gap: assert property (p_gap) else $error("next load too soon");
  property p_vtcOff;
    (tapLoad0 || tapLoad1) |-> !driftCompensationEnable0 && !driftCompensationEnable1;
  endproperty
  a_vtcOff: assert property (p_vtcOff) else $error("load with drift enable high");
  property p_pair;
    driftCompensationEnable0 == driftCompensationEnable1;
  endproperty
  a_pair: assert property (p_pair) else $error("drift enables differ");
  property p_post;
    $rose(driftCompensationEnable0) |-> sinceLoad_ff >= 4'hA;
  endproperty
  a_post: assert property (p_post) else $error("drift enable back too soon");
  property p_invert;
    slice1DataUser == $past(slice1Data) || slice1DataUser == ~$past(slice1Data);
  endproperty
  a_invert: assert property (p_invert) else $error("odd slice data mangled");
  property p_rdZero;
    !regRd |=> regRdData == 32'h0;
  endproperty
  a_rdZero: assert property (p_rdZero) else $error("read data outside its cycle");
endmodule
bind dtc_delay_tap_calibrator dtc_checker chk (.*);

/* File: tb/dtc_line_model.sv */
// Behavioural pair of delay lines answering the calibrator
module dtc_line_model #(
  parameter int ALIGN_TAPS = 50,
  parameter int TAP_PS = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [8:0] tapLoadValue0,
  input wire logic [8:0] tapLoadValue1,
  input wire logic tapLoad0,
  input wire logic tapLoad1,
  input wire logic preset,
  input wire logic [15:0] delay0Ps,
  input wire logic [15:0] delay1Ps,
  input wire logic line1Out,
  output logic [8:0] tapReadback0,
  output logic [8:0] tapReadback1
);
  // counts held still, no drift in sim
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tapReadback0 <= 9'h000;
      tapReadback1 <= 9'h000;
    end else if (preset) begin
      tapReadback0 <= 9'(ALIGN_TAPS + delay0Ps / TAP_PS);
      tapReadback1 <= 9'(delay1Ps / TAP_PS + (line1Out ? 0 : ALIGN_TAPS));
    end else begin
      if (tapLoad0) tapReadback0 <= tapLoadValue0;
      if (tapLoad1) tapReadback1 <= tapLoadValue1;
    end
  end
endmodule

/* File: tb/dtc_delay_tap_calibrator_test.sv */
// Self-checking bench for the delay tap calibrator
module dtc_delay_tap_calibrator_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic [8:0] tapReadback0, tapReadback1, tapLoadValue0, tapLoadValue1;
  logic tapLoad0, tapLoad1, driftCompensationEnable0, driftCompensationEnable1;
  logic [7:0] slice1Data = 8'h00;
  logic [7:0] slice1DataUser;
  logic preset = 1'b0;
  logic [15:0] delay0Ps = 16'h0000;
  logic [15:0] delay1Ps = 16'h0000;
  logic line1Out = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  dtc_delay_tap_calibrator dut (.*);
  dtc_line_model line (.*);
  always #5 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask
  task automatic idle();
    logic [31:0] s;
    for (int i = 0; i < 40; i++) begin
      rd(dtc_pkg::REG_STATUS, s);
      if (s[dtc_pkg::ST_BUSY] === 1'b0) return;
    end
    chk("busy", 32'h0, s);
  endtask
  task automatic setLines(input logic [15:0] d0, input logic [15:0] d1, input logic out1);
    @(posedge clk);
    delay0Ps <= d0;
    delay1Ps <= d1;
    line1Out <= out1;
    preset <= 1'b1;
    @(posedge clk);
    preset <= 1'b0;
  endtask
  task automatic load(input logic [31:0] cfg, input logic [31:0] want);
    wr(dtc_pkg::REG_CFG, cfg);
    wr(dtc_pkg::REG_WANT, want);
    wr(dtc_pkg::REG_CMD, 32'h1);
    idle();
  endtask
  task automatic cal(input logic [31:0] cfg);
    wr(dtc_pkg::REG_CFG, cfg);
    wr(dtc_pkg::REG_CMD, 32'h2);
    idle();
  endtask
  task automatic t_reset();
    rdChk("setPs", dtc_pkg::REG_SET_PS, 32'h2BC);
    rdChk("status", dtc_pkg::REG_STATUS, 32'h0);
    rdChk("unmapped", 8'h24, 32'h0);
    chk("drift", 32'h1, 32'(driftCompensationEnable0));
  endtask
  task automatic t_twoInputs();
    setLines(16'h0000, 16'h02BC, 1'b0);
    cal(32'h0);
    rdChk("align", dtc_pkg::REG_ALIGN, 32'h32);
    rdChk("tapPs", dtc_pkg::REG_TAP_PS, 32'h500);
    rdChk("status", dtc_pkg::REG_STATUS, 32'h2);
    load(32'h0, 32'h64);
    chk("rx taps", 32'h46, 32'(tapReadback0));
    rdChk("held", dtc_pkg::REG_RDBK, 32'h00BE0032);
    load(32'h18, 32'h12C);
    chk("tx taps", 32'h3C, 32'(tapReadback1));
  endtask
  task automatic t_inOut();
    setLines(16'h015E, 16'h015E, 1'b1);
    wr(dtc_pkg::REG_SET_PS, 32'h15E);
    cal(32'h2);
    rdChk("align", dtc_pkg::REG_ALIGN, 32'h32);
    rdChk("tapPs", dtc_pkg::REG_TAP_PS, 32'h500);
    load(32'h1A, 32'hC8);
    chk("tx taps", 32'h28, 32'(tapReadback1));
  endtask
  task automatic t_refuse();
    // Odd line below even: negative span, load would differ from kept count
    setLines(16'h0000, 16'h0000, 1'b1);
    cal(32'h0);
    rdChk("status", dtc_pkg::REG_STATUS, 32'h10);
    load(32'h0, 32'h64);
    chk("kept taps", 32'h32, 32'(tapReadback0));
    rdChk("status", dtc_pkg::REG_STATUS, 32'h14);
    wr(dtc_pkg::REG_STATUS, 32'h1C);
    rdChk("status", dtc_pkg::REG_STATUS, 32'h0);
  endtask
  task automatic t_count();
    load(32'h09, 32'h258);
    chk("clamped taps", 32'h1FF, 32'(tapReadback1));
    rdChk("status", dtc_pkg::REG_STATUS, 32'h8);
    load(32'h01, 32'h14);
    chk("count taps", 32'h14, 32'(tapReadback0));
    chk("drift", 32'h0, 32'(driftCompensationEnable0));
  endtask
  task automatic t_diff();
    // Stay in count format so drift enable is not raised right after a load
    wr(dtc_pkg::REG_CFG, 32'h5);
    slice1Data <= 8'h3C;
    repeat (2) @(posedge clk);
    #1;
    chk("odd data", 32'hC3, 32'(slice1DataUser));
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_twoInputs();
    t_inOut();
    t_refuse();
    t_count();
    t_diff();
    complete_run();
  end
  // Whole run is a few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
endmodule
